/* pkg/fio_pkg.sv */
// package: offsets, fields, reset values and timing for the fault/input-loss outputs
package fio_pkg;
    // apb register byte offsets
    localparam logic [7:0] OFF_OUT_SEL    = 8'h00;  // function codes for terminal and relay
    localparam logic [7:0] OFF_POLARITY   = 8'h04;  // relay_polarity_sel
    localparam logic [7:0] OFF_DEV_THRESH = 8'h08;  // deviation_threshold, percent
    localparam logic [7:0] OFF_START_ADJ  = 8'h0C;  // start_freq_adjust, input counts
    localparam logic [7:0] OFF_LOSS_CTRL  = 8'h10;  // loss stop enable, current threshold
    localparam logic [7:0] OFF_STATUS     = 8'h14;  // live flags and settle state
    localparam logic [7:0] OFF_IRQ_STAT   = 8'h18;  // sticky events
    localparam logic [7:0] OFF_IRQ_EN     = 8'h1C;
    localparam logic [7:0] OFF_IRQ_CLR    = 8'h20;  // write-one-to-clear
    // output function codes
    localparam logic [7:0] FN_PID_ERR  = 8'h04;
    localparam logic [7:0] FN_TRIP     = 8'h05;
    localparam logic [7:0] FN_IN_LOSS  = 8'h06;
    // field positions in OUT_SEL
    localparam int SEL_OC_LSB    = 0;
    localparam int SEL_RELAY_LSB = 8;
    // reset values
    localparam logic [7:0]  RST_OC_SEL     = 8'h06;
    localparam logic [7:0]  RST_RELAY_SEL  = 8'h05;
    localparam logic [1:0]  RST_POLARITY   = 2'h1;  // normally closed
    localparam logic [7:0]  RST_DEV_THRESH = 8'h03; // 3 percent
    localparam logic [11:0] RST_START_ADJ  = 12'h000;
    localparam logic [11:0] RST_CUR_4MA    = 12'h333; // 4 mA of a 20 mA full scale
    localparam logic        RST_LOSS_STOP  = 1'b1;
    localparam int IRQ_W = 3;
    localparam int IRQ_TRIP = 0;
    localparam int IRQ_LOSS = 1;
    localparam int IRQ_PID  = 2;
    // timing
    localparam longint CLK_HZ       = 40_000_000;
    localparam longint TRIP_DLY_MS  = 300;
    localparam longint SETTLE_MS    = 2000;
    localparam int TRIP_DLY_CYC = int'((CLK_HZ * TRIP_DLY_MS) / 1000);
    // longest time: rounds down, one cycle short of the 2 s limit
    localparam int SETTLE_CYC   = int'((CLK_HZ * SETTLE_MS) / 1000 - 1);
    typedef struct packed {
        logic [11:0] volt_ref;   // digitised voltage reference
        logic [11:0] cur_ref;    // digitised current reference
        logic [15:0] setpoint;   // pid target, percent scale
        logic [15:0] process_v;  // pid process value
    } fio_analog_t;
endpackage : fio_pkg

/* src/fio_outputs.sv */
// fault alarm, input-loss and pid deviation status outputs with apb registers
`timescale 1ns/1ps
module fio_outputs #(
    parameter int TRIP_DLY = fio_pkg::TRIP_DLY_CYC,
    parameter int SETTLE   = fio_pkg::SETTLE_CYC
) (
    input  wire logic               clk_sys_i,
    input  wire logic               rst_b_i,
    input  wire logic               psel_i,
    input  wire logic               penable_i,
    input  wire logic               pwrite_i,
    input  wire logic [7:0]         paddr_i,
    input  wire logic [31:0]        pwdata_i,
    output logic      [31:0]        prdata_o,
    output logic                    pready_o,
    output logic                    pslverr_o,
    input  wire logic               trip_state_i,
    input  wire logic               running_i,
    input  wire logic               power_ok_i,
    input  wire fio_pkg::fio_analog_t analog_i,
    output logic                    trip_flag_out_o,
    output logic                    input_loss_flag_o,
    output logic                    pid_error_flag_o,
    output logic                    oc_out_o,
    output logic                    relay_coil_o,
    output logic                    loss_decel_req_o,
    output logic                    irq_o
);
    typedef enum {ST_SETTLE, ST_READY} fio_relay_state_t;

    logic [7:0]  oc_sel_reg;
    logic [7:0]  relay_sel_reg;
    logic [1:0]  polarity_reg;
    logic [7:0]  dev_thresh_reg;
    logic [11:0] start_adj_reg;
    logic [11:0] cur_thresh_reg;
    logic        loss_stop_reg;
    logic [fio_pkg::IRQ_W-1:0] irq_stat_reg;
    logic [fio_pkg::IRQ_W-1:0] irq_en_reg;
    logic        trip_s1_reg, trip_s2_reg, pwr_s1_reg, pwr_s2_reg, run_s1_reg, run_s2_reg;
    logic        trip_dly_reg;
    logic [31:0] trip_cnt_reg;
    logic [31:0] settle_cnt_reg;
    fio_relay_state_t relay_state_reg;
    logic        loss_next, pid_next, relay_fn_next, relay_next, oc_next;
    logic [15:0] pid_err;
    logic        wr_en, rd_en;
    logic [fio_pkg::IRQ_W-1:0] irq_clr_next;
    fio_pkg::fio_analog_t ana_s1_reg, ana_s2_reg;

    // pick the status named by a function code; unknown codes drive inactive
    function automatic logic fn_select(input logic [7:0] code, input logic trip,
                                       input logic loss, input logic pid);
        if (code == fio_pkg::FN_TRIP) begin
            return trip;
        end else if (code == fio_pkg::FN_IN_LOSS) begin
            return loss;
        end else if (code == fio_pkg::FN_PID_ERR) begin
            return pid;
        end else begin
            return 1'b0;
        end
    endfunction : fn_select

    // pins and analog words come from outside this clock, two flops first
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            trip_s1_reg <= 1'b0;
            trip_s2_reg <= 1'b0;
            pwr_s1_reg  <= 1'b0;
            pwr_s2_reg  <= 1'b0;
            run_s1_reg  <= 1'b0;
            run_s2_reg  <= 1'b0;
        end else begin
            trip_s1_reg <= trip_state_i;
            trip_s2_reg <= trip_s1_reg;
            pwr_s1_reg  <= power_ok_i;
            pwr_s2_reg  <= pwr_s1_reg;
            run_s1_reg  <= running_i;
            run_s2_reg  <= run_s1_reg;
        end
    end

    // analog words keep sampling through reset: a zero reset value would read as
    // a dead current loop and raise a false loss event right after release
    always_ff @(posedge clk_sys_i) begin
        ana_s1_reg <= analog_i;  // words assumed stable over several clocks
        ana_s2_reg <= ana_s1_reg;
    end

    // trip flag follows the trip state after the nominal delay, both edges
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            trip_dly_reg <= 1'b0;
            trip_cnt_reg <= '0;
        end else if (trip_s2_reg == trip_dly_reg) begin
            trip_cnt_reg <= '0;  // a short glitch restarts the wait
        end else if (trip_cnt_reg >= 32'(TRIP_DLY - 1)) begin
            trip_dly_reg <= trip_s2_reg;
            trip_cnt_reg <= '0;
        end else begin
            trip_cnt_reg <= trip_cnt_reg + 32'h0000_0001;
        end
    end

    // combinational status functions; run state deliberately not consulted
    always_comb begin
        loss_next = (ana_s2_reg.volt_ref < start_adj_reg)
                  | (ana_s2_reg.cur_ref < cur_thresh_reg);
        pid_err   = (ana_s2_reg.setpoint > ana_s2_reg.process_v)
                  ? ana_s2_reg.setpoint - ana_s2_reg.process_v
                  : ana_s2_reg.process_v - ana_s2_reg.setpoint;
        pid_next  = pid_err > {8'h00, dev_thresh_reg};
        relay_fn_next = fn_select(relay_sel_reg, trip_dly_reg, input_loss_flag_o,
                                  pid_error_flag_o);
        oc_next   = fn_select(oc_sel_reg, trip_dly_reg, input_loss_flag_o, pid_error_flag_o);
        // polarity after selection: nc holds coil on while no alarm, power good and settling done
        if (polarity_reg == fio_pkg::RST_POLARITY) begin
            relay_next = (relay_state_reg == ST_READY) & pwr_s2_reg & ~relay_fn_next;
        end else begin
            relay_next = relay_fn_next;
        end
    end

    // power-up settling before an nc relay may close; restarts on a power dip
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            relay_state_reg <= ST_SETTLE;
            settle_cnt_reg  <= '0;
        end else begin
            case (relay_state_reg)
                ST_SETTLE: begin
                    if (!pwr_s2_reg) begin
                        settle_cnt_reg <= '0;
                    end else if (settle_cnt_reg >= 32'(SETTLE - 1)) begin
                        relay_state_reg <= ST_READY;
                    end else begin
                        settle_cnt_reg <= settle_cnt_reg + 32'h0000_0001;
                    end
                end
                ST_READY: begin
                    if (!pwr_s2_reg) begin
                        relay_state_reg <= ST_SETTLE;
                        settle_cnt_reg  <= '0;
                    end
                end
                default: relay_state_reg <= ST_SETTLE;
            endcase
        end
    end

    // registered outputs
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            trip_flag_out_o   <= 1'b0;
            input_loss_flag_o <= 1'b0;
            pid_error_flag_o  <= 1'b0;
            oc_out_o          <= 1'b0;
            relay_coil_o      <= 1'b0;
            loss_decel_req_o  <= 1'b0;
        end else begin
            trip_flag_out_o   <= trip_dly_reg;
            input_loss_flag_o <= loss_next;
            pid_error_flag_o  <= pid_next;
            oc_out_o          <= oc_next;
            relay_coil_o      <= relay_next;
            loss_decel_req_o  <= loss_next & loss_stop_reg;
        end
    end

    assign wr_en = psel_i & penable_i & pwrite_i;
    assign rd_en = psel_i & ~penable_i & ~pwrite_i;
    assign irq_clr_next = (wr_en && paddr_i == fio_pkg::OFF_IRQ_CLR)
                        ? pwdata_i[fio_pkg::IRQ_W-1:0] : '0;

    // software settings
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            oc_sel_reg     <= fio_pkg::RST_OC_SEL;
            relay_sel_reg  <= fio_pkg::RST_RELAY_SEL;
            polarity_reg   <= fio_pkg::RST_POLARITY;
            dev_thresh_reg <= fio_pkg::RST_DEV_THRESH;
            start_adj_reg  <= fio_pkg::RST_START_ADJ;
            cur_thresh_reg <= fio_pkg::RST_CUR_4MA;
            loss_stop_reg  <= fio_pkg::RST_LOSS_STOP;
            irq_en_reg     <= '0;
        end else if (wr_en) begin
            if (paddr_i == fio_pkg::OFF_OUT_SEL) begin
                oc_sel_reg    <= pwdata_i[fio_pkg::SEL_OC_LSB +: 8];
                relay_sel_reg <= pwdata_i[fio_pkg::SEL_RELAY_LSB +: 8];
            end else if (paddr_i == fio_pkg::OFF_POLARITY) begin
                polarity_reg <= pwdata_i[1:0];
            end else if (paddr_i == fio_pkg::OFF_DEV_THRESH) begin
                dev_thresh_reg <= pwdata_i[7:0];
            end else if (paddr_i == fio_pkg::OFF_START_ADJ) begin
                start_adj_reg <= pwdata_i[11:0];
            end else if (paddr_i == fio_pkg::OFF_LOSS_CTRL) begin
                loss_stop_reg  <= pwdata_i[0];
                cur_thresh_reg <= pwdata_i[27:16];
            end else if (paddr_i == fio_pkg::OFF_IRQ_EN) begin
                irq_en_reg <= pwdata_i[fio_pkg::IRQ_W-1:0];
            end
        end
    end

    // sticky rising-edge events; a new event beats a simultaneous clear
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            irq_stat_reg <= '0;
            irq_o        <= 1'b0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr_next)
                          | {pid_next & ~pid_error_flag_o, loss_next & ~input_loss_flag_o,
                             trip_dly_reg & ~trip_flag_out_o};
            irq_o <= |(irq_stat_reg & irq_en_reg);
        end
    end

    // apb: read data latched in setup, answer in the access cycle, no wait states
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            prdata_o  <= '0;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & (paddr_i > fio_pkg::OFF_IRQ_CLR
                         || paddr_i[1:0] != 2'b00);
            if (rd_en) begin
                if (paddr_i == fio_pkg::OFF_OUT_SEL) begin
                    prdata_o <= {16'h0000, relay_sel_reg, oc_sel_reg};
                end else if (paddr_i == fio_pkg::OFF_POLARITY) begin
                    prdata_o <= {30'h0000_0000, polarity_reg};
                end else if (paddr_i == fio_pkg::OFF_DEV_THRESH) begin
                    prdata_o <= {24'h00_0000, dev_thresh_reg};
                end else if (paddr_i == fio_pkg::OFF_START_ADJ) begin
                    prdata_o <= {20'h0_0000, start_adj_reg};
                end else if (paddr_i == fio_pkg::OFF_LOSS_CTRL) begin
                    prdata_o <= {4'h0, cur_thresh_reg, 15'h0000, loss_stop_reg};
                end else if (paddr_i == fio_pkg::OFF_STATUS) begin
                    prdata_o <= {26'h000_0000, run_s2_reg, relay_coil_o,
                                 relay_state_reg == ST_READY, pid_error_flag_o,
                                 input_loss_flag_o, trip_flag_out_o};
                end else if (paddr_i == fio_pkg::OFF_IRQ_STAT) begin
                    prdata_o <= {29'h0000_0000, irq_stat_reg};
                end else if (paddr_i == fio_pkg::OFF_IRQ_EN) begin
                    prdata_o <= {29'h0000_0000, irq_en_reg};
                end else begin
                    prdata_o <= '0;  // clear register and unmapped read as zero
                end
            end
        end
    end
endmodule : fio_outputs

/* sim/fio_checker.sv */
// checker: port-level assertions for the fault and input-loss outputs
`timescale 1ns/1ps
module fio_checker #(
    parameter int TRIP_DLY = 10
) (
    input wire logic       clk_sys_i,
    input wire logic       rst_b_i,
    input wire logic       psel_i,
    input wire logic       penable_i,
    input wire logic [7:0] paddr_i,
    input wire logic       pready_o,
    input wire logic       pslverr_o,
    input wire logic       trip_state_i,
    input wire logic       trip_flag_out_o,
    input wire logic       input_loss_flag_o,
    input wire logic       pid_error_flag_o,
    input wire logic       oc_out_o,
    input wire logic       loss_decel_req_o
);
    logic [7:0] hi_cnt;
    logic [7:0] lo_cnt;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    // raw trip run lengths, saturating so long runs never wrap
    always_ff @(posedge clk_sys_i) begin
        hi_cnt <= (!rst_b_i || !trip_state_i) ? 8'h00 : hi_cnt + {7'h00, hi_cnt != 8'hFF};
        lo_cnt <= (!rst_b_i || trip_state_i) ? 8'h00 : lo_cnt + {7'h00, lo_cnt != 8'hFF};
    end
    chk_trip_rise_late: assert property ($rose(trip_flag_out_o) |-> hi_cnt >= TRIP_DLY)
        else $error("trip flag rose before the trip delay");
    chk_trip_fall_late: assert property ($fell(trip_flag_out_o) |-> lo_cnt >= TRIP_DLY)
        else $error("trip flag fell before the trip cleared long enough");
    chk_decel_on_loss: assert property (loss_decel_req_o |->
        input_loss_flag_o || $past(input_loss_flag_o)) else $error("decel without loss");
    chk_oc_has_source: assert property (oc_out_o |->
        (trip_flag_out_o || input_loss_flag_o || pid_error_flag_o) ||
        $past(trip_flag_out_o || input_loss_flag_o || pid_error_flag_o))
        else $error("terminal high with no status source");
    chk_apb_ready: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready in access cycle");
    chk_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    chk_bad_addr: assert property (psel_i && !penable_i &&
        (paddr_i > 8'h20 || paddr_i[1:0] != 2'b00) |=> pslverr_o && pready_o)
        else $error("bad address not refused");
    chk_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
endmodule : fio_checker
bind fio_outputs fio_checker #(.TRIP_DLY(TRIP_DLY)) u_chk (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
    .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .trip_state_i(trip_state_i), .trip_flag_out_o(trip_flag_out_o),
    .input_loss_flag_o(input_loss_flag_o), .pid_error_flag_o(pid_error_flag_o),
    .oc_out_o(oc_out_o), .loss_decel_req_o(loss_decel_req_o));

/* sim/fio_alarm_loop.sv */
// partner: external alarm loop wired to the changeover relay contacts
`timescale 1ns/1ps
module fio_alarm_loop (
    input  wire logic relay_coil_i,
    output logic      common_to_b_o,
    output logic      common_to_c_o
);
    // energised coil closes common-b; a dead drive drops the coil and opens it
    assign common_to_b_o = relay_coil_i;
    assign common_to_c_o = !relay_coil_i;
endmodule : fio_alarm_loop

/* sim/fault_and_input_loss_outputs_bench.sv */
// bench: directed scenarios for the fault, input-loss and deviation outputs
`timescale 1ns/1ps
module fault_and_input_loss_outputs_bench;
    localparam int TD = 10;
    localparam int ST = 20;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr_en = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    logic trip = 1'b0, run = 1'b0, pwr = 1'b0;
    fio_pkg::fio_analog_t ana = '{12'h800, 12'hFFF, 16'h0000, 16'h0000};
    logic tf, lf, pf, oc, coil, dec, irq, to_b, to_c;
    int fails = 0, checked = 0;
    always #12.5 clk_sys_i = ~clk_sys_i;
    fio_outputs #(.TRIP_DLY(TD), .SETTLE(ST)) dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr_en), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .trip_state_i(trip),
        .running_i(run), .power_ok_i(pwr), .analog_i(ana), .trip_flag_out_o(tf),
        .input_loss_flag_o(lf), .pid_error_flag_o(pf), .oc_out_o(oc), .relay_coil_o(coil),
        .loss_decel_req_o(dec), .irq_o(irq));
    fio_alarm_loop u_loop (.relay_coil_i(coil), .common_to_b_o(to_b), .common_to_c_o(to_c));
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : tick
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checked++;
        if (got !== ex) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic chkb(input string nm, input logic ex, input logic got);
        chk(nm, {31'h0, ex}, {31'h0, got});
    endtask : chkb
    // one apb transfer; the request holds until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        psel <= 1'b1; pen <= 1'b0; pwr_en <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys_i);
        pen <= 1'b1;
        do @(posedge clk_sys_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; pen <= 1'b0;
    endtask : apb
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, ex, rd);
    endtask : rchk
    task automatic t_regs;
        rchk("out_sel", fio_pkg::OFF_OUT_SEL, 32'h0000_0506);
        rchk("polarity", fio_pkg::OFF_POLARITY, 32'h0000_0001);
        rchk("dev_thresh", fio_pkg::OFF_DEV_THRESH, 32'h0000_0003);
        rchk("irq_stat_reset", fio_pkg::OFF_IRQ_STAT, 32'h0000_0000);
        apb(1'b1, fio_pkg::OFF_DEV_THRESH, 32'h0000_0005);
        rchk("dev_thresh_wr", fio_pkg::OFF_DEV_THRESH, 32'h0000_0005);
        apb(1'b1, fio_pkg::OFF_DEV_THRESH, 32'h0000_0003);
        apb(1'b0, 8'h24, 32'h0000_0000);
        chkb("unmapped_err", 1'b1, err);
    endtask : t_regs
    task automatic t_trip;
        pwr <= 1'b1;
        tick(ST / 2);
        chkb("coil_settling", 1'b0, coil);
        tick(ST + 6);
        chkb("coil_settled", 1'b1, coil);
        chkb("loop_closed", 1'b1, to_b);
        rchk("status_settled", fio_pkg::OFF_STATUS, 32'h0000_0018);
        apb(1'b1, fio_pkg::OFF_IRQ_EN, 32'h0000_0001);
        trip <= 1'b1;
        tick(TD - 2);
        chkb("trip_early", 1'b0, tf);
        tick(8);
        chkb("trip_flag", 1'b1, tf);
        chkb("loop_open_trip", 1'b0, to_b);
        chkb("irq_raised", 1'b1, irq);
        trip <= 1'b0;
        tick(TD + 6);
        chkb("trip_cleared", 1'b0, tf);
        chkb("coil_back", 1'b1, coil);
        apb(1'b1, fio_pkg::OFF_IRQ_EN, 32'h0000_0000);
        tick(3);
        chkb("irq_masked", 1'b0, irq);
        apb(1'b1, fio_pkg::OFF_IRQ_CLR, 32'h0000_0001);
        apb(1'b1, fio_pkg::OFF_IRQ_EN, 32'h0000_0001);
        tick(3);
        chkb("irq_cleared", 1'b0, irq);
        pwr <= 1'b0;
        tick(4);
        chkb("loop_open_power", 1'b0, to_b);
        trip <= 1'b1;
        tick(TD - 4);
        trip <= 1'b0;
        tick(TD + 6);
        chkb("short_pulse", 1'b0, tf);
    endtask : t_trip
    task automatic t_polarity;
        apb(1'b1, fio_pkg::OFF_POLARITY, 32'h0000_0000);
        tick(3);
        chkb("no_power_loss", 1'b1, to_c);
        trip <= 1'b1;
        tick(TD + 6);
        chkb("no_trip_coil", 1'b1, coil);
        apb(1'b1, fio_pkg::OFF_OUT_SEL, 32'h0000_0505);
        tick(3);
        chkb("oc_trip", 1'b1, oc);
        trip <= 1'b0;
        pwr <= 1'b1;
        tick(TD + 6);
        chkb("no_idle_coil", 1'b0, coil);
    endtask : t_polarity
    task automatic t_loss;
        apb(1'b1, fio_pkg::OFF_OUT_SEL, 32'h0000_0506);
        apb(1'b1, fio_pkg::OFF_START_ADJ, 32'h0000_0100);
        run <= 1'b1;
        ana.volt_ref <= 12'h0FF;
        tick(5);
        chkb("loss_volt", 1'b1, lf);
        chkb("oc_loss", 1'b1, oc);
        chkb("decel", 1'b1, dec);
        chkb("loss_no_trip", 1'b0, tf);
        run <= 1'b0;
        tick(5);
        chkb("loss_stopped", 1'b1, lf);
        ana.volt_ref <= 12'h100;
        tick(5);
        chkb("loss_recover", 1'b0, lf);
        ana.cur_ref <= 12'h332;
        tick(5);
        chkb("loss_cur", 1'b1, lf);
        ana.cur_ref <= 12'h333;
        tick(5);
        chkb("cur_ok", 1'b0, lf);
    endtask : t_loss
    task automatic t_pid;
        apb(1'b1, fio_pkg::OFF_OUT_SEL, 32'h0000_0504);
        ana.setpoint <= 16'h0064;
        ana.process_v <= 16'h0067;
        tick(5);
        chkb("pid_at_limit", 1'b0, pf);
        ana.process_v <= 16'h0068;
        tick(5);
        chkb("pid_over", 1'b1, pf);
        chkb("oc_pid", 1'b1, oc);
        apb(1'b1, fio_pkg::OFF_DEV_THRESH, 32'h0000_0005);
        tick(5);
        chkb("pid_new_thresh", 1'b0, pf);
        ana.setpoint <= 16'h006E;
        tick(5);
        chkb("pid_abs", 1'b1, pf);
        apb(1'b1, fio_pkg::OFF_OUT_SEL, 32'h0000_0507);
        tick(3);
        chkb("oc_other_code", 1'b0, oc);
    endtask : t_pid
    task automatic end_of_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    // watchdog: the scenarios need well under a thousand cycles
    initial begin
        #(25 * 5000);
        fails++;
        end_of_test();
    end
    initial begin
        tick(4);
        rst_b_i <= 1'b1;
        t_regs();
        t_trip();
        t_polarity();
        t_loss();
        t_pid();
        end_of_test();
    end
endmodule : fault_and_input_loss_outputs_bench
